// File: hw/fsr_status_one.sv
// Status register one of a serial flash, with serial command front end.
// Summary of operation
// - Opcode 05h reads status, 01h writes registers, 30h clears error flags.
// - Opcode 06h sets the write enable latch, 04h clears it.
// - Register write ignored while status write disable is set and protect pin low.
// - Protect pin high or disable bit zero lets register write change protection.
// - Failed program operation sets the program error flag.
// - Program into protected sector or locked region sets program error.
// - Failed erase or erase of protected sector sets erase error.
// - Whole array erase hitting protected sector leaves erase error clear.
// - Error flags are read only; only clear status or soft reset zeroes them.
// - Any block protect bit set protects the area; volatility chosen by config.
// - Whole array erase runs only with all block protect bits zero.
// - Latch zero refuses register write, program and erase; latch one accepts.
// - Successful program, register write or erase clears the latch.
// - Power up, hardware reset and software reset clear the latch.
// - Accepting a register write leaves the latch alone; its successful end clears it.
// - Busy flag stays one during any operation; new operations are ignored.
// - While busy only reads, suspends, clear status and soft reset are taken.
// - Suspend commands are taken only while matching array operation runs.
// - Errors update while busy; busy holds until clear status arrives.
`timescale 1ns/1ps
`default_nettype none
module fsr_status_one
   import fsr_pkg::*;
#(
   parameter logic [7:0] OP_READ_STATUS_TWO = 8'h07,
   parameter logic [7:0] OP_PROGRAM         = 8'h02,
   parameter logic [7:0] OP_SECTOR_ERASE    = 8'hd8,
   parameter logic [7:0] OP_WHOLE_ERASE     = 8'h60,
   parameter logic [7:0] OP_ERASE_SUSPEND   = 8'h75,
   parameter logic [7:0] OP_PROGRAM_SUSPEND = 8'h85,
   parameter logic [7:0] OP_SOFT_RESET      = 8'hf0
) (
   // System clock and reset.
   input  wire logic       mclk,
   input  wire logic       resetn,
   // Serial link pins.
   input  wire logic       sck,
   input  wire logic       cs_n,
   input  wire logic       si,
   output logic            so,
   output logic            so_oe,
   input  wire logic       wp_n,
   // Nonvolatile contents loaded after reset.
   input  wire logic       nv_status_write_disable,
   input  wire logic [2:0] nv_bp,
   input  wire logic       protect_volatility_select,
   // Program and erase engine requests.
   output logic            eng_start,
   output logic [2:0]      eng_kind,
   output logic [7:0]      wrr_sr_data,
   output logic [7:0]      wrr_cr_data,
   output logic            wrr_cr_valid,
   output logic            erase_suspend,
   output logic            program_suspend,
   output logic            soft_reset_pulse,
   // Program and erase engine results.
   input  wire logic       eng_done,
   input  wire logic       eng_fail,
   input  wire logic       eng_prot_fault,
   // Register contents.
   output logic [7:0]      status_register_one
);

   // Reset synchroniser.
   logic       rst_m1_r;
   logic       rst_n_s;
   // Link domain state.
   logic [2:0] bitcnt_r;
   logic [1:0] nbytes_r;
   logic [6:0] shin_r;
   logic [7:0] opcode_r;
   logic [7:0] d1_r;
   logic [7:0] d2_r;
   logic [1:0] frame_bytes_r;
   logic       whole_r;
   logic       frame_tgl_r;
   logic       rd_tgl_r;
   logic [7:0] so_sh_r;
   logic       so_oe_r;
   logic       rd_cmd;
   logic [7:0] byte_in;
   logic [1:0] nbytes_nxt;
   // System domain synchronisers.
   logic       cs_m1_r, cs_m2_r, cs_m3_r;
   logic       wp_m1_r, wp_m2_r;
   logic       ft_m1_r, ft_m2_r, ft_seen_r;
   logic       rt_m1_r, rt_m2_r, rt_m3_r;
   // Status state.
   logic       status_write_disable_r;
   logic       perr_r;
   logic       eerr_r;
   logic [2:0] bp_r;
   logic       wel_r;
   logic       busy_r;
   fsr_kind_t  kind_r;
   logic       ld_pend_r;
   logic [7:0] stat_hold_r;
   logic [7:0] status_word;
   // Engine request registers.
   logic       eng_start_r;
   fsr_kind_t  eng_kind_r;
   logic [7:0] wrr_sr_r;
   logic [7:0] wrr_cr_r;
   logic       wrr_cr_valid_r;
   logic       erase_suspend_cmd_r;
   logic       program_suspend_cmd_r;
   logic       srst_r;
   // Command decode.
   logic       cmd_go;
   logic       errs;
   logic       wp_lock;
   logic       do_set_write_latch_cmd, do_clear_write_latch_cmd, do_clear_status_cmd, do_srst, do_wrr;
   logic       do_prog, do_serase, do_bulk, do_erase_suspend_cmd, do_program_suspend_cmd, do_start;
   logic       perr_set, eerr_set, op_ok;
   fsr_kind_t  start_kind;

   // Reset release through two flip-flops.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rst_m1_r <= 1'b0;
         rst_n_s  <= 1'b0;
      end else begin
         rst_m1_r <= 1'b1;
         rst_n_s  <= rst_m1_r;
      end
   end

   // Bit and byte counters, cleared whenever the frame is deselected.
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         bitcnt_r <= 3'h0;
         nbytes_r <= 2'h0;
      end else begin
         bitcnt_r <= bitcnt_r + 3'h1;
         nbytes_r <= nbytes_nxt;
      end
   end

   // Byte count after the current edge, saturating.
   assign nbytes_nxt = (bitcnt_r == BIT_LAST && nbytes_r != BYTES_MAX) ?
                       nbytes_r + 2'h1 : nbytes_r;
   assign byte_in    = {shin_r, si};

   // Serial input capture; these words hold after the frame for the system side.
   always_ff @(posedge sck or negedge rst_n_s) begin
      if (!rst_n_s) begin
         shin_r        <= 7'h00;
         opcode_r      <= 8'h00;
         d1_r          <= 8'h00;
         d2_r          <= 8'h00;
         frame_bytes_r <= 2'h0;
         whole_r       <= 1'b0;
      end else begin
         shin_r        <= byte_in[6:0];
         frame_bytes_r <= nbytes_nxt;
         whole_r       <= (bitcnt_r == BIT_LAST);
         if (bitcnt_r == BIT_LAST) begin
            unique case (nbytes_r)
               2'h0:    opcode_r <= byte_in;
               2'h1:    d1_r     <= byte_in;
               2'h2:    d2_r     <= byte_in;
               default: d2_r     <= d2_r;
            endcase
         end
      end
   end

   // Event toggles toward the system side: frame start and status snapshot.
   always_ff @(posedge sck or negedge rst_n_s) begin
      if (!rst_n_s) begin
         frame_tgl_r <= 1'b0;
         rd_tgl_r    <= 1'b0;
      end else begin
         if (bitcnt_r == 3'h0 && nbytes_r == 2'h0) begin
            frame_tgl_r <= ~frame_tgl_r;
         end
         if (bitcnt_r == BIT_RD_REQ) begin
            rd_tgl_r <= ~rd_tgl_r;
         end
      end
   end

   // A status read is active once its opcode byte is complete.
   assign rd_cmd = (nbytes_r != 2'h0) &&
                   (opcode_r == OP_READ_STATUS_ONE || opcode_r == OP_READ_STATUS_TWO);

   // Output shifter on the falling edge; the snapshot reloads at each byte start.
   // msb first, repeating
   always_ff @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         so_sh_r <= 8'h00;
         so_oe_r <= 1'b0;
      end else if (bitcnt_r == 3'h0 && rd_cmd) begin
         so_sh_r <= (opcode_r == OP_READ_STATUS_ONE) ? stat_hold_r : 8'h00;
         so_oe_r <= 1'b1;
      end else begin
         so_sh_r <= {so_sh_r[6:0], 1'b0};
      end
   end

   assign so    = so_sh_r[7];
   assign so_oe = so_oe_r;

   // Pin and toggle synchronisers into the system clock.
   always_ff @(posedge mclk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         cs_m1_r <= 1'b1;
         cs_m2_r <= 1'b1;
         cs_m3_r <= 1'b1;
         wp_m1_r <= 1'b1;
         wp_m2_r <= 1'b1;
         ft_m1_r <= 1'b0;
         ft_m2_r <= 1'b0;
         rt_m1_r <= 1'b0;
         rt_m2_r <= 1'b0;
         rt_m3_r <= 1'b0;
      end else begin
         cs_m1_r <= cs_n;
         cs_m2_r <= cs_m1_r;
         cs_m3_r <= cs_m2_r;
         wp_m1_r <= wp_n;
         wp_m2_r <= wp_m1_r;
         ft_m1_r <= frame_tgl_r;
         ft_m2_r <= ft_m1_r;
         rt_m1_r <= rd_tgl_r;
         rt_m2_r <= rt_m1_r;
         rt_m3_r <= rt_m2_r;
      end
   end

   // A command runs at frame end, only for a fresh frame of whole bytes.
   assign cmd_go = cs_m2_r && !cs_m3_r && (ft_m2_r != ft_seen_r) && whole_r;

   // Marks the frame as consumed.
   always_ff @(posedge mclk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         ft_seen_r <= 1'b0;
      end else if (cs_m2_r && !cs_m3_r) begin
         ft_seen_r <= ft_m2_r;
      end
   end

   // Status snapshot for the link, refreshed on each request toggle.
   always_ff @(posedge mclk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         stat_hold_r <= 8'h00;
      end else if (rt_m2_r != rt_m3_r) begin
         stat_hold_r <= status_word;
      end
   end

   assign errs    = perr_r || eerr_r;
   assign wp_lock = status_write_disable_r && !wp_m2_r;

   // Command decode; busy gates all operation starts.
   // new operations ignored while busy
   assign do_set_write_latch_cmd   = cmd_go && opcode_r == OP_SET_LATCH && frame_bytes_r == BYTES_ONE
                      && !busy_r;
   assign do_clear_write_latch_cmd   = cmd_go && opcode_r == OP_CLR_LATCH && frame_bytes_r == BYTES_ONE
                      && !busy_r;
   assign do_clear_status_cmd   = cmd_go && opcode_r == OP_CLR_STATUS && frame_bytes_r == BYTES_ONE;
   assign do_srst   = cmd_go && opcode_r == OP_SOFT_RESET && frame_bytes_r == BYTES_ONE;
   // latch gates writes, programs and erases
   assign do_wrr    = cmd_go && opcode_r == OP_WRITE_REGS && frame_bytes_r >= BYTES_TWO
                      && wel_r && !busy_r && !wp_lock;
   assign do_prog   = cmd_go && opcode_r == OP_PROGRAM && frame_bytes_r == BYTES_MAX
                      && wel_r && !busy_r;
   assign do_serase = cmd_go && opcode_r == OP_SECTOR_ERASE && frame_bytes_r == BYTES_MAX
                      && wel_r && !busy_r;
   assign do_bulk   = cmd_go && opcode_r == OP_WHOLE_ERASE && frame_bytes_r == BYTES_ONE
                      && wel_r && !busy_r && bp_r == 3'h0;
   // suspend only for a matching operation
   assign do_erase_suspend_cmd   = cmd_go && opcode_r == OP_ERASE_SUSPEND && frame_bytes_r == BYTES_ONE
                      && busy_r && !errs
                      && (kind_r == FSR_KIND_SERASE || kind_r == FSR_KIND_BULK);
   assign do_program_suspend_cmd   = cmd_go && opcode_r == OP_PROGRAM_SUSPEND && frame_bytes_r == BYTES_ONE
                      && busy_r && !errs && kind_r == FSR_KIND_PROG;
   assign do_start  = do_wrr || do_prog || do_serase || do_bulk;

   // Kind of the operation being started.
   always_comb begin
      start_kind = FSR_KIND_NONE;
      if (do_wrr) begin
         start_kind = FSR_KIND_REGWR;
      end else if (do_prog) begin
         start_kind = FSR_KIND_PROG;
      end else if (do_serase) begin
         start_kind = FSR_KIND_SERASE;
      end else if (do_bulk) begin
         start_kind = FSR_KIND_BULK;
      end
   end

   // Error events reported by the engine while busy.
   // program errors, register write failure included
   assign perr_set = busy_r && (eng_fail || eng_prot_fault)
                     && (kind_r == FSR_KIND_PROG || kind_r == FSR_KIND_REGWR);
   // a protected hit during whole erase is not an error
   assign eerr_set = busy_r && ((kind_r == FSR_KIND_SERASE && (eng_fail || eng_prot_fault))
                     || (kind_r == FSR_KIND_BULK && eng_fail));
   assign op_ok    = busy_r && eng_done && !eng_fail && !perr_set && !eerr_set && !errs;

   // Write enable latch.
   always_ff @(posedge mclk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         wel_r <= WEL_RST;
      end else if (do_srst) begin
         wel_r <= WEL_RST;
      end else if (do_set_write_latch_cmd) begin
         wel_r <= 1'b1;
      end else if (do_clear_write_latch_cmd) begin
         wel_r <= 1'b0;
      // cleared only on success, never by the write itself
      end else if (op_ok) begin
         wel_r <= 1'b0;
      end
   end

   // Busy flag and kind of running operation.
   always_ff @(posedge mclk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         busy_r <= BUSY_RST;
         kind_r <= FSR_KIND_NONE;
      end else if (do_srst) begin
         busy_r <= BUSY_RST;
         kind_r <= FSR_KIND_NONE;
      end else if (do_start) begin
         busy_r <= 1'b1;
         kind_r <= start_kind;
      end else if (op_ok) begin
         busy_r <= 1'b0;
         kind_r <= FSR_KIND_NONE;
      // errors keep busy until clear status
      end else if (do_clear_status_cmd && errs && !perr_set && !eerr_set) begin
         busy_r <= 1'b0;
         kind_r <= FSR_KIND_NONE;
      end
   end

   // Error flags; a new error wins over a clear in the same cycle.
   // only clear status or soft reset zero them
   always_ff @(posedge mclk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         perr_r <= ERR_RST;
         eerr_r <= ERR_RST;
      end else begin
         if (perr_set) begin
            perr_r <= 1'b1;
         end else if (do_clear_status_cmd || do_srst) begin
            perr_r <= 1'b0;
         end
         if (eerr_set) begin
            eerr_r <= 1'b1;
         end else if (do_clear_status_cmd || do_srst) begin
            eerr_r <= 1'b0;
         end
      end
   end

   // Protection bits: loaded from storage after reset, then changed by writes.
   always_ff @(posedge mclk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         ld_pend_r <= 1'b1;
         status_write_disable_r    <= STATUS_WRITE_DISABLE_RST;
         bp_r      <= BP_RST;
      end else if (ld_pend_r) begin
         ld_pend_r <= 1'b0;
         status_write_disable_r    <= nv_status_write_disable;
         // volatile protect bits start all set
         bp_r      <= protect_volatility_select ? BP_VOL_ON : nv_bp;
      end else if (do_srst && protect_volatility_select) begin
         bp_r <= BP_VOL_ON;
      // write changes disable and protect bits
      end else if (do_wrr) begin
         status_write_disable_r <= d1_r[STATUS_WRITE_DISABLE_POS];
         bp_r   <= d1_r[BP_HI:BP_LO];
      end
   end

   // Requests toward the program and erase engine.
   always_ff @(posedge mclk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         eng_start_r    <= 1'b0;
         eng_kind_r     <= FSR_KIND_NONE;
         wrr_sr_r       <= 8'h00;
         wrr_cr_r       <= 8'h00;
         wrr_cr_valid_r <= 1'b0;
         erase_suspend_cmd_r         <= 1'b0;
         program_suspend_cmd_r         <= 1'b0;
         srst_r         <= 1'b0;
      end else begin
         eng_start_r <= do_start;
         erase_suspend_cmd_r      <= do_erase_suspend_cmd;
         program_suspend_cmd_r      <= do_program_suspend_cmd;
         srst_r      <= do_srst;
         if (do_start) begin
            eng_kind_r <= start_kind;
         end
         if (do_wrr) begin
            wrr_sr_r       <= d1_r;
            wrr_cr_r       <= d2_r;
            wrr_cr_valid_r <= (frame_bytes_r == BYTES_MAX);
         end
      end
   end

   // Register word and outputs.
   assign status_word = {status_write_disable_r, perr_r, eerr_r, bp_r, wel_r, busy_r};
   assign status_register_one = status_word;
   assign eng_start        = eng_start_r;
   assign eng_kind         = eng_kind_r;
   assign wrr_sr_data      = wrr_sr_r;
   assign wrr_cr_data      = wrr_cr_r;
   assign wrr_cr_valid     = wrr_cr_valid_r;
   assign erase_suspend    = erase_suspend_cmd_r;
   assign program_suspend  = program_suspend_cmd_r;
   assign soft_reset_pulse = srst_r;

   // Checks on the system clock.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n_s);

   sequence s_clear_status_cmd_taken;
      do_clear_status_cmd && (errs || !busy_r) && !perr_set && !eerr_set;
   endsequence

   sequence s_flags_gone;
      !perr_r && !eerr_r ##0 !busy_r;
   endsequence

   a_set_write_latch_cmd_sets_latch: assert property (do_set_write_latch_cmd |=> wel_r && !busy_r)
      else $error("latch not set after set command");
   a_clear_write_latch_cmd_clears_latch: assert property (do_clear_write_latch_cmd |=> !wel_r)
      else $error("latch not cleared after clear command");
   a_wrr_locked_out: assert property (
      cmd_go && opcode_r == OP_WRITE_REGS && wp_lock && !busy_r
      |=> $stable(status_write_disable_r) && $stable(bp_r) && !eng_start)
      else $error("register write taken while protected");
   a_wrr_keeps_flags: assert property (
      do_wrr |=> $stable(perr_r) && $stable(eerr_r) && $stable(wel_r) ##1 eng_start == 1'b0)
      else $error("register write changed read only bits");
   a_bulk_refused: assert property (
      cmd_go && opcode_r == OP_WHOLE_ERASE && bp_r != 3'h0 && !busy_r |=> !eng_start && !busy_r)
      else $error("whole erase started while protected");
   a_success_clears: assert property (
      op_ok |=> !wel_r && !busy_r)
      else $error("successful operation left latch or busy set");
   a_busy_ignores: assert property (
      busy_r && cmd_go && !do_srst |=> $stable(wel_r) && !eng_start)
      else $error("command acted on while busy");
   a_error_holds_busy: assert property (
      (perr_r || eerr_r) && !do_clear_status_cmd && !do_srst |=> busy_r)
      else $error("busy dropped while an error flag is set");
   a_clear_status_cmd_recovers: assert property (
      s_clear_status_cmd_taken |=> s_flags_gone)
      else $error("clear status did not return to standby");
   a_bulk_prot_quiet: assert property (
      busy_r && kind_r == FSR_KIND_BULK && eng_prot_fault && !eng_fail && !eerr_r
      |=> !eerr_r)
      else $error("whole erase protected hit set erase error");
   a_srst_clears: assert property (do_srst |=> !wel_r [*2])
      else $error("latch not cleared by soft reset");

endmodule : fsr_status_one
`default_nettype wire

// File: pkg/fsr_pkg.sv
// Shared constants and types for the flash status register one logic.
package fsr_pkg;

   // Command codes decoded by the status logic.
   localparam logic [7:0] OP_READ_STATUS_ONE = 8'h05;
   localparam logic [7:0] OP_WRITE_REGS      = 8'h01;
   localparam logic [7:0] OP_SET_LATCH       = 8'h06;
   localparam logic [7:0] OP_CLR_LATCH       = 8'h04;
   localparam logic [7:0] OP_CLR_STATUS      = 8'h30;

   // Field positions inside status register one.
   localparam int STATUS_WRITE_DISABLE_POS = 7;
   localparam int PERR_POS = 6;
   localparam int EERR_POS = 5;
   localparam int BP_HI    = 4;
   localparam int BP_LO    = 2;
   localparam int WEL_POS  = 1;
   localparam int BUSY_POS = 0;

   // Field position of the protection volatility select in config register one.
   localparam int PROTECT_VOLATILITY_SELECT_POS = 3;

   // Values after reset.
   localparam logic       WEL_RST   = 1'b0;
   localparam logic       ERR_RST   = 1'b0;
   localparam logic       BUSY_RST  = 1'b0;
   localparam logic       STATUS_WRITE_DISABLE_RST  = 1'b0;
   localparam logic [2:0] BP_RST    = 3'h0;
   localparam logic [2:0] BP_VOL_ON = 3'h7;

   // Serial framing counts.
   localparam logic [2:0] BIT_LAST   = 3'h7;
   localparam logic [2:0] BIT_RD_REQ = 3'h4;
   localparam logic [1:0] BYTES_MAX  = 2'h3;
   localparam logic [1:0] BYTES_ONE  = 2'h1;
   localparam logic [1:0] BYTES_TWO  = 2'h2;

   // Kind of operation that holds the device busy.
   typedef enum logic [2:0] {
      FSR_KIND_NONE   = 3'b000,
      FSR_KIND_PROG   = 3'b001,
      FSR_KIND_SERASE = 3'b010,
      FSR_KIND_BULK   = 3'b011,
      FSR_KIND_REGWR  = 3'b100
   } fsr_kind_t;

endpackage : fsr_pkg

// File: verification/fsr_host_model.sv
// Host controller model that frames serial commands in mode 0.
`timescale 1ns/1ps
`default_nettype none
module fsr_host_model (
   // Serial link pins.
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   input  wire logic so
);
   // The clock stands low and chip select high between frames.
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end

   task automatic frame(input logic [31:0] b, input int nb, output logic [7:0] rd);
      int i;
      cs_n = 1'b0;
      for (i = 0; i < nb * 8; i++) begin
         si = b[31 - i];
         #62.5 sck = 1'b1;
         rd = {rd[6:0], so};
         #62.5 sck = 1'b0;
      end
      #62.5 cs_n = 1'b1;
      // Released data line shows the inverse so a stale value is never mistaken.
      si = ~si;
   endtask : frame
endmodule : fsr_host_model
`default_nettype wire

// File: verification/fsr_status_one_bench.sv
// Self-checking bench for status register one and its serial command front end.
`timescale 1ns/1ps
`default_nettype none
module fsr_status_one_bench
   import fsr_pkg::*;
;
   logic       mclk = 1'b0;
   logic       resetn, wp_n, eng_done, eng_fail, eng_prot_fault, pvs;
   wire        sck, cs_n, si, so;
   wire        eng_start_w, esus_w, psus_w, srst_w, oe, cr_valid;
   logic [7:0] st, rd, sr_data, cr_data;
   logic [2:0] kind;
   int         n_errors, num_checks, n_start, n_esus, n_psus, n_srst, n_oe;

   fsr_status_one DUT (.mclk(mclk), .resetn(resetn), .sck(sck), .cs_n(cs_n), .si(si),
      .so(so), .so_oe(oe), .wp_n(wp_n), .nv_status_write_disable(1'b0), .nv_bp(3'h0),
      .protect_volatility_select(pvs), .eng_start(eng_start_w), .eng_kind(kind),
      .wrr_sr_data(sr_data), .wrr_cr_data(cr_data), .wrr_cr_valid(cr_valid),
      .erase_suspend(esus_w),
      .program_suspend(psus_w), .soft_reset_pulse(srst_w), .eng_done(eng_done),
      .eng_fail(eng_fail), .eng_prot_fault(eng_prot_fault), .status_register_one(st));

   fsr_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .so(so));

   // System clock of 8 ns.
   always #4 mclk = ~mclk;

   // Counts one-cycle pulses from the design.
   always @(posedge mclk) begin
      n_start += eng_start_w;
      n_esus += esus_w;
      n_psus += psus_w;
      n_srst += srst_w;
   end

   // Counts link clock rises at which the data output is enabled.
   always @(posedge sck) n_oe += (oe === 1'b1);

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t seen 0x%h expected 0x%h", $time, seen, exp);
      end
   endtask : chk

   // One frame, then wait past the fixed command latency.
   task automatic cmd(input logic [31:0] b, input int nb);
      host.frame(b, nb, rd);
      repeat (8) @(posedge mclk);
      #1;
   endtask : cmd

   // One engine result pulse.
   task automatic eng(input logic d, input logic f, input logic p);
      eng_done = d;
      eng_fail = f;
      eng_prot_fault = p;
      @(posedge mclk);
      #1;
      eng_done = 1'b0;
      eng_fail = 1'b0;
      eng_prot_fault = 1'b0;
      repeat (3) @(posedge mclk);
      #1;
   endtask : eng

   task automatic finish_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test

   // Watchdog well past the expected run length.
   initial begin
      #400us;
      n_errors++;
      finish_test();
   end

   initial begin
      resetn = 1'b0;
      wp_n = 1'b1;
      pvs = 1'b0;
      eng_done = 1'b0;
      eng_fail = 1'b0;
      eng_prot_fault = 1'b0;
      repeat (16) @(posedge mclk);
      #1 resetn = 1'b1;
      repeat (8) @(posedge mclk);
      #1;
      chk(st, 8'h00);
      cmd({8'h01, 8'h9c, 16'h0000}, 2);
      chk(st, 8'h00);
      cmd({8'h06, 24'h0}, 1);
      chk(st, 8'h02);
      cmd({8'h05, 24'h0}, 3);
      chk(rd, 8'h02);
      chk(8'(n_oe), 8'h10);
      cmd({8'h04, 24'h0}, 1);
      chk(st, 8'h00);
      cmd({8'h06, 24'h0}, 1);
      cmd({8'h01, 8'h9c, 16'h0000}, 2);
      chk(st, 8'h9f);
      chk({5'h00, kind}, 8'h04);
      chk(sr_data, 8'h9c);
      chk({7'h00, cr_valid}, 8'h00);
      cmd({8'h04, 24'h0}, 1);
      chk(st, 8'h9f);
      eng(1'b1, 1'b0, 1'b0);
      chk(st, 8'h9c);
      wp_n = 1'b0;
      cmd({8'h06, 24'h0}, 1);
      cmd({8'h01, 24'h0}, 2);
      chk(st, 8'h9e);
      chk(8'(n_start), 8'h01);
      wp_n = 1'b1;
      cmd({8'h01, 24'h0}, 2);
      chk(st, 8'h03);
      eng(1'b1, 1'b0, 1'b0);
      cmd({8'h06, 24'h0}, 1);
      cmd({8'h60, 24'h0}, 1);
      chk({5'h00, kind}, 8'h03);
      eng(1'b1, 1'b0, 1'b1);
      chk(st, 8'h00);
      cmd({8'h06, 24'h0}, 1);
      cmd({8'h02, 24'h0}, 4);
      chk(st, 8'h03);
      cmd({8'h01, 24'h0}, 2);
      chk(st, 8'h03);
      eng(1'b0, 1'b1, 1'b0);
      chk(st, 8'h43);
      eng(1'b1, 1'b0, 1'b0);
      chk(st, 8'h43);
      cmd({8'h01, 24'h0}, 2);
      chk(st, 8'h43);
      cmd({8'h30, 24'h0}, 1);
      chk(st, 8'h02);
      cmd({8'h04, 24'h0}, 1);
      chk(st, 8'h00);
      cmd({8'h06, 24'h0}, 1);
      cmd({8'h02, 24'h0}, 4);
      eng(1'b0, 1'b0, 1'b1);
      chk(st, 8'h43);
      cmd({8'h30, 24'h0}, 1);
      cmd({8'hd8, 24'h0}, 4);
      chk({5'h00, kind}, 8'h02);
      cmd({8'h85, 24'h0}, 1);
      chk(8'(n_psus), 8'h00);
      cmd({8'h75, 24'h0}, 1);
      chk(8'(n_esus), 8'h01);
      eng(1'b0, 1'b0, 1'b1);
      chk(st, 8'h23);
      cmd({8'h30, 24'h0}, 1);
      cmd({8'h01, 8'h04, 8'h5a, 8'h00}, 3);
      chk(cr_data, 8'h5a);
      chk({7'h00, cr_valid}, 8'h01);
      eng(1'b1, 1'b0, 1'b0);
      cmd({8'h06, 24'h0}, 1);
      chk(st, 8'h06);
      cmd({8'h60, 24'h0}, 1);
      chk(st, 8'h06);
      chk(8'(n_start), 8'h07);
      pvs = 1'b1;
      cmd({8'hf0, 24'h0}, 1);
      chk(st, 8'h1c);
      chk(8'(n_oe), 8'h10);
      chk(8'(n_srst), 8'h01);
      finish_test();
   end
endmodule : fsr_status_one_bench
`default_nettype wire
